// ### logic/pmes_pkg.sv
// Purpose: Shared constants for the peak and event status register bank
// Assumes: Registers sit at their printed 16-bit offsets on the host port
// Notes:   Status bit positions are listed here and used by name in the logic; the bench uses bare numbers

package pmes_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] PMES_ADDR_CUR_PEAK = 16'he500;
  localparam logic [15:0] PMES_ADDR_VOLT_PEAK = 16'he501;
  localparam logic [15:0] PMES_ADDR_STATUS = 16'he502;

  // ----------------------------------------------------------------
  // Peak register layout and reset values
  // ----------------------------------------------------------------
  localparam int PMES_PEAK_W = 24;
  localparam int PMES_PEAK_PHASE_LSB = 24;
  localparam int PMES_PEAK_ZERO_LSB = 27;
  localparam int PMES_PEAK_CNT_W = 8;
  localparam logic [31:0] PMES_PEAK_RST = 32'h0000_0000;
  localparam logic [31:0] PMES_STATUS_RST = 32'h0000_0000;
  localparam logic [8:0] PMES_SIGN_RST = 9'h000;

  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int PMES_ST_TOT_ACT = 0;
  localparam int PMES_ST_FUND_ACT = 1;
  localparam int PMES_ST_TOT_REACT = 2;
  localparam int PMES_ST_FUND_REACT = 3;
  localparam int PMES_ST_APPARENT = 4;
  localparam int PMES_ST_LINE_DONE = 5;
  localparam int PMES_ST_ACT_SIGN_A = 6;
  localparam int PMES_ST_SUM_PATH1 = 9;
  localparam int PMES_ST_REACT_SIGN_A = 10;
  localparam int PMES_ST_SUM_PATH2 = 13;
  localparam int PMES_ST_PULSE_ONE = 14;
  localparam int PMES_ST_DSP_DONE = 17;
  localparam int PMES_ST_SUM_PATH3 = 18;
  localparam int PMES_ST_USED = 19;

  // ----------------------------------------------------------------
  // Control bit positions (accumulation config, pulse mode, sign reg)
  // ----------------------------------------------------------------
  localparam int PMES_ACC_ACT_SEL_BIT = 6;
  localparam int PMES_ACC_REACT_SEL_BIT = 7;
  localparam int PMES_PULSE_SEL_W = 3;
  localparam int PMES_PULSE_DIS_LSB = 9;
  localparam int PMES_SIGN_ACT_LSB = 0;
  localparam int PMES_SIGN_SUM1 = 3;
  localparam int PMES_SIGN_REACT_LSB = 4;
  localparam int PMES_SIGN_SUM2 = 7;
  localparam int PMES_SIGN_SUM3 = 8;

endpackage

// ### logic/pmes_peak_if.sv
// Purpose: Carries samples in and peak results out of one peak tracker
// Assumes: Every signal is on i_sys_clk
// Notes:   Phase vectors are one bit per phase, A in bit 0

`timescale 1ns/1ps

interface pmes_peak_if;
  logic [23:0] sample;
  logic [2:0] sample_phase;
  logic sample_valid;
  logic half_tick;
  logic [7:0] interval;
  logic [23:0] result_value;
  logic [2:0] result_phase;
  logic result_stb;

  // Source side feeds samples, tracker side answers with results
  modport src (output sample, sample_phase, sample_valid, half_tick,
    interval, input result_value, result_phase, result_stb);
  modport trk (input sample, sample_phase, sample_valid, half_tick,
    interval, output result_value, result_phase, result_stb);
endinterface

// ### logic/pmes_peak_track.sv
// Purpose: Keeps the largest sample over a window of half line cycles
// Assumes: Interval of zero means no window ends and no result is given
// Notes:   Equal nonzero maxima from two phases mark both phase bits

`timescale 1ns/1ps

module pmes_peak_track
  import pmes_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Sample and result carrier
  pmes_peak_if.trk pk
);

  logic [23:0] max_r;
  logic [2:0] phase_r;
  logic [7:0] half_cnt_r;
  logic window_end;

  // Window closes on the half cycle that completes the count
  assign window_end = pk.half_tick && (pk.interval != 8'h00) &&
    (half_cnt_r >= pk.interval - 8'h01);

  // ----------------------------------------------------------------
  // Half cycle counter
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      half_cnt_r <= 8'h00;
    end else if (window_end) begin
      half_cnt_r <= 8'h00;
    end else if (pk.half_tick) begin
      half_cnt_r <= half_cnt_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Running maximum; a sample in the closing cycle opens the next one
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      max_r <= 24'h000000;
      phase_r <= 3'h0;
    end else if (window_end) begin
      max_r <= pk.sample_valid ? pk.sample : 24'h000000;
      phase_r <= pk.sample_valid ? pk.sample_phase : 3'h0;
    end else if (pk.sample_valid && (pk.sample > max_r)) begin
      max_r <= pk.sample;
      phase_r <= pk.sample_phase;
    end else if (pk.sample_valid && (pk.sample == max_r) &&
        (max_r != 24'h000000)) begin
      phase_r <= phase_r | pk.sample_phase;
    end
  end

  // ----------------------------------------------------------------
  // Result hand-off, one strobe per finished window
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pk.result_value <= 24'h000000;
      pk.result_phase <= 3'h0;
      pk.result_stb <= 1'b0;
    end else begin
      pk.result_stb <= window_end;
      if (window_end) begin
        pk.result_value <= max_r;
        pk.result_phase <= phase_r;
      end
    end
  end

endmodule

// ### logic/pmes_change_det.sv
// Purpose: Flags a change, or only a falling edge, on each bit of a vector
// Assumes: Input comes from logic on the same clock
// Notes:   No event in the first cycle after reset, while history fills

`timescale 1ns/1ps

module pmes_change_det #(
  parameter int W = 3,
  parameter bit FALL_ONLY = 1'b0
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Watched vector and events
  input wire logic [W-1:0] i_level,
  output logic [W-1:0] o_event
);

  logic [W-1:0] prev_r;
  logic primed_r;

  // History of the watched vector
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prev_r <= '0;
      primed_r <= 1'b0;
    end else begin
      prev_r <= i_level;
      primed_r <= 1'b1;
    end
  end

  // Per-bit comparison against history
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      if (FALL_ONLY) begin : g_fall
        assign o_event[g] = primed_r && prev_r[g] && !i_level[g];
      end else begin : g_any
        assign o_event[g] = primed_r && (prev_r[g] != i_level[g]);
      end
    end
  endgenerate

endmodule

// ### logic/pmes_status_regs.sv
// Purpose: Peak capture registers and first event status register
// Assumes: All event inputs come from logic on i_sys_clk
// Notes:   Status bits clear by writing one; a same-cycle event wins
//
// Summary of operation
// - Current peak register low 24 bits hold the last interval's peak.
// - Current peak bits 24..26 mark phase A, B, C as the source.
// - Voltage peak register low 24 bits hold the last interval's peak.
// - Voltage peak bits 24..26 mark phase A, B, C as the source.
// - Peak bits 31..27 read zero; both peak registers reset to zero.
// - Status bit 0 sets on a bit 30 change of total active energy.
// - Status bit 1 sets on a bit 30 change of fundamental active energy.
// - Status bit 2 sets on a bit 30 change of total reactive energy.
// - Status bit 3 sets on bit 30 change of fundamental reactive energy.
// - Status bit 4 sets on a bit 30 change of apparent energy.
// - Status bit 5 sets when line-cycle accumulation completes.
// - Bits 6..8 set on active sign change; type by config bit 6.
// - Bits 10..12 set on reactive sign change; type by config bit 7.
// - Bits 9, 13, 18 set on summed path power sign change.
// - Bits 14..16 set on a falling edge of pulse outputs one to three.
// - Pulse flags still set while the pulse pin is disabled.
// - Pulse path power type chosen by 3-bit pulse mode fields.
// - Status bit 17 sets when the periodic DSP pass finishes.
// - Status bits 31..19 always read zero.
// - Missing fundamental or reactive metering forces those flags zero.
// - Peak interval length comes from the 8-bit interval count.

`timescale 1ns/1ps

module pmes_status_regs
  import pmes_pkg::*;
#(
  parameter bit HAS_FUND = 1'b1,
  parameter bit HAS_REACTIVE = 1'b1
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // Host register port
  input wire logic [15:0] i_reg_addr,
  input wire logic i_reg_wr_en,
  input wire logic i_reg_rd_en,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_rd_valid,
  // Peak detector samples
  input wire logic [23:0] i_cur_sample,
  input wire logic [2:0] i_cur_sample_phase,
  input wire logic i_cur_sample_valid,
  input wire logic [23:0] i_volt_sample,
  input wire logic [2:0] i_volt_sample_phase,
  input wire logic i_volt_sample_valid,
  input wire logic i_half_cycle_tick,
  input wire logic [7:0] i_peak_interval_count,
  // Energy accumulator bit 30, kind*3+phase: tot act, fund act,
  // tot react, fund react, apparent
  input wire logic [14:0] i_energy_bit30,
  // Line cycle and DSP events
  input wire logic i_line_accum_mode,
  input wire logic i_line_cycle_done,
  input wire logic i_dsp_pass_done,
  // Power signs per phase and accumulation config
  input wire logic [7:0] i_accumulation_config,
  input wire logic [2:0] i_active_sign_total,
  input wire logic [2:0] i_active_sign_fund,
  input wire logic [2:0] i_reactive_sign_total,
  input wire logic [2:0] i_reactive_sign_fund,
  // Summed sign for each power type code, and pulse controls
  input wire logic [7:0] i_sum_sign_by_type,
  input wire logic [11:0] i_pulse_mode_register,
  input wire logic [2:0] i_pulse_level,
  // Sign register view
  output logic [8:0] o_power_sign_register
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] cur_peak_r;
  logic [31:0] volt_peak_r;
  logic [31:0] status_r;
  logic [31:0] status_nxt;
  logic [31:0] event_vec;
  logic [31:0] clear_vec;
  logic [8:0] sign_nxt;
  logic [8:0] sign_event;
  logic [14:0] energy_event;
  logic [4:0] energy_kind;
  logic [2:0] pulse_event;
  logic [2:0] sum_sign;
  logic up_r;

  pmes_peak_if cur_if ();
  pmes_peak_if volt_if ();

  // Picks the summed sign of the power type a 3-bit field selects
  function automatic logic pick_sign(input logic [7:0] signs,
      input logic [2:0] sel);
    pick_sign = signs[sel];
  endfunction

  // Mask of the flags that this product variant can produce
  function automatic logic [31:0] variant_mask(input bit fund,
      input bit react);
    logic [31:0] m;
    m = {{(32 - PMES_ST_USED){1'b0}}, {PMES_ST_USED{1'b1}}};
    if (!fund) begin
      m[PMES_ST_FUND_ACT] = 1'b0;
      m[PMES_ST_FUND_REACT] = 1'b0;
    end
    if (!react) begin
      m[PMES_ST_TOT_REACT] = 1'b0;
      m[PMES_ST_FUND_REACT] = 1'b0;
      m[PMES_ST_REACT_SIGN_A +: 3] = 3'h0;
    end
    variant_mask = m;
  endfunction

  // ----------------------------------------------------------------
  // Peak trackers
  // ----------------------------------------------------------------
  // Window length from the interval count
  assign cur_if.sample = i_cur_sample;
  assign cur_if.sample_phase = i_cur_sample_phase;
  assign cur_if.sample_valid = i_cur_sample_valid;
  assign cur_if.half_tick = i_half_cycle_tick;
  assign cur_if.interval = i_peak_interval_count;
  assign volt_if.sample = i_volt_sample;
  assign volt_if.sample_phase = i_volt_sample_phase;
  assign volt_if.sample_valid = i_volt_sample_valid;
  assign volt_if.half_tick = i_half_cycle_tick;
  assign volt_if.interval = i_peak_interval_count;

  pmes_peak_track u_cur_peak (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .pk (cur_if.trk)
  );

  pmes_peak_track u_volt_peak (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .pk (volt_if.trk)
  );

  // Peak registers load on each finished window, top bits held zero
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cur_peak_r <= PMES_PEAK_RST;
      volt_peak_r <= PMES_PEAK_RST;
    end else begin
      if (cur_if.result_stb) begin
        // Value phase marks zero top
        cur_peak_r <= {5'h00, cur_if.result_phase, cur_if.result_value};
      end
      if (volt_if.result_stb) begin
        // Value phase marks zero top
        volt_peak_r <= {5'h00, volt_if.result_phase,
          volt_if.result_value};
      end
    end
  end

  // ----------------------------------------------------------------
  // Sign selection and sign register
  // ----------------------------------------------------------------
  // Path sign follows the pulse mode type field of each path
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_path
      assign sum_sign[p] = pick_sign(i_sum_sign_by_type,
        i_pulse_mode_register[p*PMES_PULSE_SEL_W +: PMES_PULSE_SEL_W]);
    end
  endgenerate

  // Total or fundamental chosen by config bits 6 and 7
  always_comb begin
    sign_nxt = PMES_SIGN_RST;
    sign_nxt[PMES_SIGN_ACT_LSB +: 3] =
      i_accumulation_config[PMES_ACC_ACT_SEL_BIT] ?
      i_active_sign_fund : i_active_sign_total;
    sign_nxt[PMES_SIGN_REACT_LSB +: 3] =
      i_accumulation_config[PMES_ACC_REACT_SEL_BIT] ?
      i_reactive_sign_fund : i_reactive_sign_total;
    sign_nxt[PMES_SIGN_SUM1] = sum_sign[0];
    sign_nxt[PMES_SIGN_SUM2] = sum_sign[1];
    sign_nxt[PMES_SIGN_SUM3] = sum_sign[2];
  end

  // Registered view of the selected signs
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_power_sign_register <= PMES_SIGN_RST;
    end else begin
      o_power_sign_register <= sign_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Change detectors
  // ----------------------------------------------------------------
  // A selector flip may itself look like a sign change; accepted
  pmes_change_det #(.W(9), .FALL_ONLY(1'b0)) u_sign_det (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_level (sign_nxt),
    .o_event (sign_event)
  );

  pmes_change_det #(.W(15), .FALL_ONLY(1'b0)) u_energy_det (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_level (i_energy_bit30),
    .o_event (energy_event)
  );

  // Raw pulse levels, not gated by the disable bits
  pmes_change_det #(.W(3), .FALL_ONLY(1'b1)) u_pulse_det (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_level (i_pulse_level),
    .o_event (pulse_event)
  );

  // Any of the three phases of each energy kind
  genvar k;
  generate
    for (k = 0; k < 5; k++) begin : g_kind
      assign energy_kind[k] = |energy_event[k*3 +: 3];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Event status register
  // ----------------------------------------------------------------
  always_comb begin
    event_vec = 32'h0000_0000;
    event_vec[PMES_ST_TOT_ACT +: 5] = energy_kind;
    event_vec[PMES_ST_LINE_DONE] =
      i_line_accum_mode && i_line_cycle_done;
    event_vec[PMES_ST_ACT_SIGN_A +: 3] =
      sign_event[PMES_SIGN_ACT_LSB +: 3];
    event_vec[PMES_ST_REACT_SIGN_A +: 3] =
      sign_event[PMES_SIGN_REACT_LSB +: 3];
    event_vec[PMES_ST_SUM_PATH1] = sign_event[PMES_SIGN_SUM1];
    event_vec[PMES_ST_SUM_PATH2] = sign_event[PMES_SIGN_SUM2];
    event_vec[PMES_ST_SUM_PATH3] = sign_event[PMES_SIGN_SUM3];
    event_vec[PMES_ST_PULSE_ONE +: 3] = pulse_event;
    event_vec[PMES_ST_DSP_DONE] = i_dsp_pass_done;
  end

  // Write-one-to-clear; a new event in the same cycle wins
  assign clear_vec = (i_reg_wr_en && (i_reg_addr == PMES_ADDR_STATUS)) ?
    i_reg_wdata : 32'h0000_0000;
  assign status_nxt = ((status_r & ~clear_vec) | event_vec) &
    variant_mask(HAS_FUND, HAS_REACTIVE);

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      status_r <= PMES_STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Register read port; unmapped offsets read zero
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 32'h0000_0000;
      o_reg_rd_valid <= 1'b0;
      up_r <= 1'b0;
    end else begin
      o_reg_rd_valid <= i_reg_rd_en;
      up_r <= 1'b1;
      if (!i_reg_rd_en) begin
        o_reg_rdata <= o_reg_rdata;
      end else if (i_reg_addr == PMES_ADDR_CUR_PEAK) begin
        o_reg_rdata <= cur_peak_r;
      end else if (i_reg_addr == PMES_ADDR_VOLT_PEAK) begin
        o_reg_rdata <= volt_peak_r;
      end else if (i_reg_addr == PMES_ADDR_STATUS) begin
        o_reg_rdata <= status_r;
      end else begin
        o_reg_rdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_dsp_clear;
    clear_vec[PMES_ST_DSP_DONE] && !i_dsp_pass_done;
  endsequence

  sequence s_cur_result;
    cur_if.result_stb ##1 1'b1;
  endsequence

  a_peak_top_zero: assert property (
    cur_peak_r[31:27] == 5'h00 && volt_peak_r[31:27] == 5'h00)
    else $error("peak register top bits not zero");

  a_cur_peak_load: assert property (
    s_cur_result |-> cur_peak_r[23:0] == $past(cur_if.result_value))
    else $error("current peak value not loaded");

  a_cur_phase_load: assert property (
    cur_if.result_stb |=> cur_peak_r[26:24] == $past(cur_if.result_phase))
    else $error("current peak phase not loaded");

  a_volt_peak_load: assert property (
    volt_if.result_stb |=> volt_peak_r[26:0] ==
      {$past(volt_if.result_phase), $past(volt_if.result_value)})
    else $error("voltage peak value or phase not loaded");

  a_energy_flag_set: assert property (
    up_r && (i_energy_bit30[2:0] != $past(i_energy_bit30[2:0]))
    |=> status_r[PMES_ST_TOT_ACT])
    else $error("total active energy flag not set");

  a_pulse_flag_set: assert property (
    up_r && $fell(i_pulse_level[0]) |=> status_r[PMES_ST_PULSE_ONE])
    else $error("pulse one flag not set on falling edge");

  a_dsp_flag_set: assert property (
    i_dsp_pass_done |=> status_r[PMES_ST_DSP_DONE] [*1])
    else $error("dsp pass flag not set");

  a_line_flag_gate: assert property (
    !status_r[PMES_ST_LINE_DONE] && !(i_line_accum_mode &&
      i_line_cycle_done) |=> !status_r[PMES_ST_LINE_DONE])
    else $error("line cycle flag set outside accumulation mode");

  a_status_reserved: assert property (
    status_r[31:PMES_ST_USED] == 13'h0000)
    else $error("reserved status bits not zero");

  a_clear_w1c: assert property (
    s_dsp_clear
    |=> !status_r[PMES_ST_DSP_DONE])
    else $error("status flag not cleared by writing one");

  a_clear_zero_keeps: assert property (
    status_r[PMES_ST_DSP_DONE] && !clear_vec[PMES_ST_DSP_DONE]
    |=> status_r[PMES_ST_DSP_DONE])
    else $error("status flag lost without a clear");

endmodule

// ### verification/pmes_status_regs_tb.sv
// Purpose: Self-checking bench for the peak and event status registers
// Assumes: Register strobes are one-cycle pulses on i_sys_clk
// Notes:   Expected words come from a small model kept in the bench

`timescale 1ns/1ps

module tb;
  import pmes_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] addr = '0;
  logic wr_en = 1'b0, rd_en = 1'b0;
  logic [31:0] wdata = '0, rdata, rdata_l, seed = 32'h45d1;
  logic rd_valid, cur_v = 1'b0, volt_v = 1'b0, tick = 1'b0;
  logic [23:0] cur_s = '0, volt_s = '0, cmax, vmax;
  logic [2:0] cur_ph = '0, volt_ph = '0, cph, vph;
  logic [7:0] pk_int = '0, acc = '0, sum = '0;
  logic [14:0] en30 = '0;
  logic lmode = 1'b0, ldone = 1'b0, dsp = 1'b0;
  logic [2:0] as_t = '0, as_f = '0, rs_t = '0, rs_f = '0;
  logic [2:0] plev = 3'b111;
  logic [11:0] pmode = 12'hed1; // Paths pick codes 1..3, pins disabled
  logic [8:0] psign, es = '0;
  int errors = 0, checked = 0;
  int sb[3] = '{9, 13, 18};
  int sr[3] = '{3, 7, 8};

  // Free-running 125 MHz clock
  always #4 clk = ~clk;

  pmes_status_regs dut_u (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_reg_addr(addr),
    .i_reg_wr_en(wr_en), .i_reg_rd_en(rd_en), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_reg_rd_valid(rd_valid),
    .i_cur_sample(cur_s), .i_cur_sample_phase(cur_ph),
    .i_cur_sample_valid(cur_v), .i_volt_sample(volt_s),
    .i_volt_sample_phase(volt_ph), .i_volt_sample_valid(volt_v),
    .i_half_cycle_tick(tick), .i_peak_interval_count(pk_int),
    .i_energy_bit30(en30), .i_line_accum_mode(lmode),
    .i_line_cycle_done(ldone), .i_dsp_pass_done(dsp),
    .i_accumulation_config(acc), .i_active_sign_total(as_t),
    .i_active_sign_fund(as_f), .i_reactive_sign_total(rs_t),
    .i_reactive_sign_fund(rs_f), .i_sum_sign_by_type(sum),
    .i_pulse_mode_register(pmode), .i_pulse_level(plev),
    .o_power_sign_register(psign)
  );

  // Variant without fundamental or reactive metering
  pmes_status_regs #(.HAS_FUND(1'b0), .HAS_REACTIVE(1'b0)) dut_lite (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_reg_addr(addr),
    .i_reg_wr_en(wr_en), .i_reg_rd_en(rd_en), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata_l), .o_reg_rd_valid(),
    .i_cur_sample(cur_s), .i_cur_sample_phase(cur_ph),
    .i_cur_sample_valid(cur_v), .i_volt_sample(volt_s),
    .i_volt_sample_phase(volt_ph), .i_volt_sample_valid(volt_v),
    .i_half_cycle_tick(tick), .i_peak_interval_count(pk_int),
    .i_energy_bit30(en30), .i_line_accum_mode(lmode),
    .i_line_cycle_done(ldone), .i_dsp_pass_done(dsp),
    .i_accumulation_config(acc), .i_active_sign_total(as_t),
    .i_active_sign_fund(as_f), .i_reactive_sign_total(rs_t),
    .i_reactive_sign_fund(rs_f), .i_sum_sign_by_type(sum),
    .i_pulse_mode_register(pmode), .i_pulse_level(plev),
    .o_power_sign_register()
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic cmp32(input string n, input logic [31:0] e,
                       input logic [31:0] s);
    checked++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask

  task automatic cmp9(input string n, input logic [8:0] e,
                      input logic [8:0] s);
    checked++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask

  // Read answer is looked at in its one valid cycle
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] el;
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    cmp32("rd_valid", 32'h1, {31'h0, rd_valid});
    cmp32("rdata", e, rdata);
    // Lite variant drops fundamental and reactive flags
    el = (a == PMES_ADDR_STATUS) ? (e & 32'hffff_e3f1) : e;
    cmp32("rdata_lite", el, rdata_l);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Status check, zero write keeps flags, ones write clears them
  task automatic flag(input logic [31:0] e);
    repeat (4) @(posedge clk);
    rd_chk(PMES_ADDR_STATUS, e);
    wr(PMES_ADDR_STATUS, 32'h0);
    rd_chk(PMES_ADDR_STATUS, e);
    wr(PMES_ADDR_STATUS, 32'hffff_ffff);
    rd_chk(PMES_ADDR_STATUS, 32'h0);
  endtask

  task automatic stop_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #200000;
    errors++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(PMES_ADDR_CUR_PEAK, 32'h0);
    rd_chk(PMES_ADDR_VOLT_PEAK, 32'h0);
    rd_chk(16'he5ff, 32'h0);
    for (int i = 0; i < 15; i++) begin
      @(posedge clk);
      en30[i] <= ~en30[i];
      flag(32'h1 << (i / 3));
    end
    // Line done only counts in line accumulation mode
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      lmode <= m[0];
      ldone <= 1'b1;
      @(posedge clk);
      ldone <= 1'b0;
      flag(m[0] ? 32'h20 : 32'h0);
    end
    @(posedge clk);
    dsp <= 1'b1;
    @(posedge clk);
    dsp <= 1'b0;
    flag(32'h1 << 17);
    // Falling edge flags, rising edge does nothing
    for (int p = 0; p < 3; p++) begin
      @(posedge clk);
      plev[p] <= 1'b0;
      flag(32'h1 << (14 + p));
      @(posedge clk);
      plev[p] <= 1'b1;
      flag(32'h0);
    end
    for (int p = 0; p < 3; p++) begin
      @(posedge clk);
      as_t[p] <= 1'b1;
      rs_t[p] <= 1'b1;
      sum[p + 1] <= 1'b1;
      es[p] = 1'b1;
      es[4 + p] = 1'b1;
      es[sr[p]] = 1'b1;
      flag((32'h11 << (6 + p)) | (32'h1 << sb[p]));
      cmp9("sign", es, psign);
    end
    // Switch to fundamental; the switch itself may flag, so clear it
    @(posedge clk);
    acc <= 8'hc0;
    wr(PMES_ADDR_STATUS, 32'hffff_ffff);
    repeat (4) @(posedge clk);
    wr(PMES_ADDR_STATUS, 32'hffff_ffff);
    @(posedge clk);
    as_f[0] <= 1'b1;
    rs_f[0] <= 1'b1;
    as_t[1] <= 1'b0;
    flag(32'h440);
    cmp9("sign", 9'h199, psign);
    // Peak windows of one then two half cycles
    for (int w = 0; w < 2; w++) begin
      cmax = '0;
      vmax = '0;
      @(posedge clk);
      pk_int <= 8'(w + 1);
      for (int p = 0; p < 3; p++) begin
        @(posedge clk);
        seed = xs(seed);
        cur_s <= seed[23:0];
        if (seed[23:0] > cmax) begin
          cmax = seed[23:0];
          cph = 3'b1 << p;
        end
        seed = xs(seed);
        volt_s <= seed[23:0];
        if (seed[23:0] > vmax) begin
          vmax = seed[23:0];
          vph = 3'b1 << p;
        end
        cur_ph <= 3'b1 << p;
        volt_ph <= 3'b1 << p;
        cur_v <= 1'b1;
        volt_v <= 1'b1;
      end
      @(posedge clk);
      cur_v <= 1'b0;
      volt_v <= 1'b0;
      repeat (w + 1) begin
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
      end
      repeat (3) @(posedge clk);
      rd_chk(PMES_ADDR_CUR_PEAK, {5'h0, cph, cmax});
      rd_chk(PMES_ADDR_VOLT_PEAK, {5'h0, vph, vmax});
    end
    wr(PMES_ADDR_CUR_PEAK, 32'hffff_ffff);
    rd_chk(PMES_ADDR_CUR_PEAK, {5'h0, cph, cmax});
    stop_test();
  end
endmodule
